// ===== core/rai_pkg.sv
/*
  Constants, types and state layout for the reset and interrupt control block.
  Assumes a single 50 MHz clock that is also the high-frequency core clock.
*/
// Function
// - Malfunction reset lasts at most 24 clocks.
// - Power-up may give one spurious malfunction reset.
// - Reset loads reset vector, clears flags, latches.
// - External pin low 12 clocks before reset.
// - Pin high releases reset at reset vector.
// - Fetch from protected area raises address trap.
// - Trap select chooses reset or trap interrupt.
// - Watchdog select chooses reset or interrupt.
// - Illegal oscillator disable causes system clock reset.
// - After trap reset core fetches reset vector.
// - Twenty sources, four non-maskable, nesting allowed.
// - Request sets pending latch, latch asks CPU.
// - Maskable needs global and source enable.
// - Fixed priority: reset, non-maskable, maskable ascending.
// - Non-maskable vectors and latch numbers fixed.
// - Maskable indices four to nineteen, vector map.
// - Converter latch loss on lower acceptance documented; here accept clears only the presented source latch.
// - Accepted source latch cleared by hardware.
// - Accept saves global mask, then clears it.
package rai_pkg;
  localparam int CLK_NS = 20;
  localparam int MAL_RESET_NS = 480;
  localparam int EXT_LOW_NS = 240;
  localparam int MAL_CYC = (MAL_RESET_NS / CLK_NS < 1) ? 1 : MAL_RESET_NS / CLK_NS;
  localparam int EXT_CYC = (EXT_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ENABLE_OFS = 8'h04;
  localparam logic [7:0] PENDING_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  localparam int GMASK_BIT = 0;
  localparam int PIN0_EN_BIT = 1;
  localparam int RAM_TRAP_BIT = 2;
  localparam int TRAP_OUT_BIT = 3;
  localparam int WDT_OUT_BIT = 4;
  localparam int SYSTEM_CLOCK_SELECT_BIT = 5;
  localparam int LOW_OSC_BIT = 6;
  localparam int HIGH_OSC_BIT = 7;
  localparam logic [7:0] CTRL_RST = 8'hD8;
  localparam logic [19:0] LATCH_MASK = 20'hFFFFC;
  localparam logic [19:0] ENABLE_MASK = 20'hFFFF0;
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_SWI = 16'hFFFC;
  localparam logic [15:0] VEC_TRAP = 16'hFFFA;
  localparam logic [15:0] VEC_WDT = 16'hFFF8;
  localparam logic [15:0] VEC_LOW_BASE = 16'hFFF6;
  localparam logic [15:0] VEC_HIGH_BASE = 16'hFFBE;
  localparam logic [4:0] IDX_SWI = 5'h00;
  localparam logic [4:0] IDX_TRAP = 5'h02;
  localparam logic [4:0] IDX_WDT = 5'h03;
  localparam logic [4:0] IDX_PIN0 = 5'h04;
  localparam logic [4:0] IDX_SPLIT = 5'h10;
  localparam logic [4:0] IDX_LAST = 5'h13;

  typedef enum logic [2:0] {
    RAI_RUN = 3'b001,
    RAI_EXT = 3'b010,
    RAI_MAL = 3'b100
  } rai_rst_state_type;

  typedef struct packed {
    logic valid;
    logic sfr;
    logic dbr;
    logic ram;
  } rai_fetch_type;

  typedef struct packed {
    logic accept;
    logic ret;
    logic restored_mask;
    logic swi_req;
    logic undef_req;
    rai_fetch_type fetch;
  } rai_core_type;

  typedef struct packed {
    logic req;
    logic [4:0] index;
    logic [15:0] vector;
    logic saved_mask;
  } rai_irq_type;

  typedef struct packed {
    logic pin_s1;
    logic pin_s2;
    logic [4:0] ext_cnt;
    logic [4:0] mal_cnt;
    rai_rst_state_type state;
    logic core_reset_n;
    logic [3:0] cause;
    logic [7:0] ctrl;
    logic [19:0] enable;
    logic [19:0] pending;
    rai_irq_type irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rai_state_type;
endpackage

// ===== core/rai_ctrl.sv
/*
  Reset sequencer, interrupt latches, enables and priority encoder with an APB register port.
  Assumes the core pulses accept and return, holds software requests until accepted,
  and that the watchdog and address decode live outside on the same clock.
*/
`timescale 1ns/10ps
module rai_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_reset_pin_n,
  input wire logic watchdog_expired,
  input wire logic [15:0] maskable_req,
  input wire rai_pkg::rai_core_type core,
  output rai_pkg::rai_irq_type irq,
  output logic core_reset_n,
  output logic high_osc_enable,
  output logic low_osc_enable,
  output logic system_clock_select
);
  import rai_pkg::*;

  rai_state_type s_r;
  rai_state_type s_nxt;

  function automatic logic [15:0] vec_of(input logic [4:0] idx);
    logic [15:0] k;
    k = {11'h000, idx};
    if (idx == IDX_SWI) begin
      vec_of = VEC_SWI;
    end else if (idx == IDX_TRAP) begin
      vec_of = VEC_TRAP;
    end else if (idx == IDX_WDT) begin
      vec_of = VEC_WDT;
    end else if (idx < IDX_SPLIT) begin
      vec_of = 16'(VEC_LOW_BASE - ((k - 16'h0004) << 1));
    end else begin
      vec_of = 16'(VEC_HIGH_BASE - ((k - 16'h0010) << 1));
    end
  endfunction

  function automatic logic decoded(input logic [7:0] a);
    decoded = (a == CTRL_OFS) || (a == ENABLE_OFS) || (a == PENDING_OFS) ||
              (a == STATUS_OFS);
  endfunction

  logic setup;
  logic wr;
  logic wr_ctrl;
  logic [7:0] new_ctrl;
  logic trap_hit;
  logic trap_rst;
  logic wdt_rst;
  logic clk_rst;
  logic ext_hit;
  logic run;
  logic [19:0] sets;
  logic [19:0] ready_src;
  logic found;
  logic [4:0] pick;

  always_comb begin
    s_nxt = s_r;
    run = (s_r.state == RAI_RUN);
    setup = psel && !penable;
    wr = psel && penable && s_r.pready && pwrite && !s_r.pslverr;
    wr_ctrl = wr && (paddr == CTRL_OFS);
    new_ctrl = pwdata[7:0];
    // Bus answers in the access cycle right after setup.
    s_nxt.pready = setup;
    s_nxt.pslverr = setup && !decoded(paddr);
    s_nxt.prdata = 32'h00000000;
    if (setup && !pwrite) begin
      case (paddr)
        CTRL_OFS: s_nxt.prdata = {24'h000000, s_r.ctrl};
        ENABLE_OFS: s_nxt.prdata = {12'h000, s_r.enable};
        PENDING_OFS: s_nxt.prdata = {12'h000, s_r.pending};
        STATUS_OFS: s_nxt.prdata = {11'h000, s_r.irq.index, 7'h00, s_r.irq.req, 4'h0,
                                    s_r.cause};
        default: s_nxt.prdata = 32'h00000000;
      endcase
    end
    // Pin passes two flip-flops before anything looks at it.
    s_nxt.pin_s1 = ext_reset_pin_n;
    s_nxt.pin_s2 = s_r.pin_s1;
    if (s_r.pin_s2) begin
      s_nxt.ext_cnt = 5'h00;
    end else if (s_r.ext_cnt != 5'(EXT_CYC)) begin
      s_nxt.ext_cnt = 5'(s_r.ext_cnt + 5'h01);
    end
    ext_hit = (s_nxt.ext_cnt == 5'(EXT_CYC));
    trap_hit = run && core.fetch.valid &&
               (core.fetch.sfr || core.fetch.dbr ||
                (core.fetch.ram && s_r.ctrl[RAM_TRAP_BIT]));
    trap_rst = trap_hit && s_r.ctrl[TRAP_OUT_BIT];
    wdt_rst = run && watchdog_expired && s_r.ctrl[WDT_OUT_BIT];
    // A rejected clock write is dropped so both oscillators keep running.
    clk_rst = run && wr_ctrl &&
              ((!new_ctrl[HIGH_OSC_BIT] && !new_ctrl[LOW_OSC_BIT] &&
                s_r.ctrl[HIGH_OSC_BIT] && s_r.ctrl[LOW_OSC_BIT]) ||
               (!new_ctrl[HIGH_OSC_BIT] && s_r.ctrl[HIGH_OSC_BIT] &&
                !s_r.ctrl[SYSTEM_CLOCK_SELECT_BIT]) ||
               (!new_ctrl[LOW_OSC_BIT] && s_r.ctrl[LOW_OSC_BIT] &&
                s_r.ctrl[SYSTEM_CLOCK_SELECT_BIT]));
    case (s_r.state)
      RAI_RUN: begin
        if (ext_hit) begin
          s_nxt.state = RAI_EXT;
          s_nxt.cause = 4'h1;
        end else if (trap_rst || wdt_rst || clk_rst) begin
          s_nxt.state = RAI_MAL;
          s_nxt.mal_cnt = 5'(MAL_CYC - 1);
          s_nxt.cause = {clk_rst, wdt_rst, trap_rst, 1'b0};
        end
      end
      RAI_EXT: begin
        if (s_r.pin_s2) begin
          s_nxt.state = RAI_RUN;
        end
      end
      RAI_MAL: begin
        if (ext_hit) begin
          s_nxt.state = RAI_EXT;
          s_nxt.cause = 4'h1;
        end else if (s_r.mal_cnt == 5'h00) begin
          s_nxt.state = RAI_RUN;
        end else begin
          s_nxt.mal_cnt = 5'(s_r.mal_cnt - 5'h01);
        end
      end
      default: s_nxt.state = RAI_RUN;
    endcase
    // Software writes: AND semantics on latches, a zero clears a bit and a one leaves it unchanged.
    if (wr_ctrl && !clk_rst) begin
      s_nxt.ctrl = new_ctrl;
    end
    if (wr && (paddr == ENABLE_OFS)) begin
      s_nxt.enable = pwdata[19:0] & ENABLE_MASK;
    end
    if (wr && (paddr == PENDING_OFS)) begin
      s_nxt.pending = s_r.pending & pwdata[19:0];
    end
    if (run && core.accept && s_r.irq.req) begin
      s_nxt.irq.saved_mask = s_r.ctrl[GMASK_BIT];
      s_nxt.ctrl[GMASK_BIT] = 1'b0;
      // Only the presented source is cleared, so a converter request is never lost.
      if (s_r.irq.index != IDX_SWI) begin
        s_nxt.pending[s_r.irq.index] = 1'b0;
      end
    end else if (run && core.ret) begin
      s_nxt.ctrl[GMASK_BIT] = core.restored_mask;
    end
    sets = {maskable_req, watchdog_expired && !s_r.ctrl[WDT_OUT_BIT],
            trap_hit && !s_r.ctrl[TRAP_OUT_BIT], 2'b00};
    if (run) begin
      s_nxt.pending = (s_nxt.pending | sets) & LATCH_MASK;
    end
    // Priority pick from the state being written, so it matches next cycle.
    ready_src = s_nxt.pending & s_nxt.enable &
                {20{s_nxt.ctrl[GMASK_BIT]}};
    ready_src[IDX_PIN0] = ready_src[IDX_PIN0] && s_nxt.ctrl[PIN0_EN_BIT];
    ready_src[IDX_TRAP] = s_nxt.pending[IDX_TRAP];
    ready_src[IDX_WDT] = s_nxt.pending[IDX_WDT];
    found = 1'b0;
    pick = IDX_SWI;
    for (int i = 19; i >= 2; i--) begin
      if (ready_src[i]) begin
        found = 1'b1;
        pick = 5'(i);
      end
    end
    if (core.swi_req || core.undef_req) begin
      found = 1'b1;
      pick = IDX_SWI;
    end
    s_nxt.irq.req = found && !core.accept;
    s_nxt.irq.index = found ? pick : IDX_SWI;
    s_nxt.irq.vector = found ? vec_of(pick) : VEC_RESET;
    // Internal reset reinitialises control state but not the cause record.
    s_nxt.core_reset_n = (s_nxt.state == RAI_RUN);
    if (s_nxt.state != RAI_RUN) begin
      s_nxt.ctrl = CTRL_RST;
      s_nxt.enable = 20'h00000;
      s_nxt.pending = 20'h00000;
      s_nxt.irq.req = 1'b0;
      s_nxt.irq.index = IDX_SWI;
      s_nxt.irq.vector = VEC_RESET;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.state <= RAI_MAL;
      s_r.mal_cnt <= 5'(MAL_CYC - 1);
      s_r.pin_s1 <= 1'b1;
      s_r.pin_s2 <= 1'b1;
      s_r.ctrl <= CTRL_RST;
      s_r.irq.vector <= VEC_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign irq = s_r.irq;
  assign core_reset_n = s_r.core_reset_n;
  assign high_osc_enable = s_r.ctrl[HIGH_OSC_BIT];
  assign low_osc_enable = s_r.ctrl[LOW_OSC_BIT];
  assign system_clock_select = s_r.ctrl[SYSTEM_CLOCK_SELECT_BIT];

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  mal_start_a: assert property (run && !ext_hit && (trap_rst || wdt_rst || clk_rst)
    |=> !core_reset_n && s_r.mal_cnt == 5'(MAL_CYC - 1))
    else $error("Malfunction reset did not start with full count.");
  mal_end_a: assert property (s_r.state == RAI_MAL && s_r.mal_cnt == 5'h00 && !ext_hit
    |=> core_reset_n)
    else $error("Malfunction reset did not end on time.");
  ext_min_a: assert property ($rose(s_r.state == RAI_EXT)
    |-> $past(!s_r.pin_s2, 1) && s_r.ext_cnt == 5'(EXT_CYC))
    else $error("External reset taken before the minimum low time.");
  ext_release_a: assert property (s_r.state == RAI_EXT && s_r.pin_s2
    |=> core_reset_n ##0 (irq.vector == VEC_RESET || irq.req))
    else $error("External reset not released when pin went high.");
  reset_clear_a: assert property (!core_reset_n
    |-> s_r.pending == 20'h00000 && s_r.enable == 20'h00000 && s_r.ctrl == CTRL_RST
        && !irq.req && irq.vector == VEC_RESET)
    else $error("Reset did not initialise control state.");
  trap_latch_a: assert property (trap_hit && !s_r.ctrl[TRAP_OUT_BIT] && !ext_hit
    |=> s_r.pending[IDX_TRAP])
    else $error("Address trap interrupt latch not set.");
  wdt_reset_a: assert property (run && watchdog_expired && s_r.ctrl[WDT_OUT_BIT]
    |=> !core_reset_n)
    else $error("Watchdog reset not applied.");
  accept_mask_a: assert property (run && core.accept && irq.req && !ext_hit
    |=> !s_r.ctrl[GMASK_BIT] && irq.saved_mask == $past(s_r.ctrl[GMASK_BIT]))
    else $error("Global mask not saved and cleared on accept.");
  mask_gate_a: assert property (irq.req && irq.index >= IDX_PIN0
    |-> s_r.ctrl[GMASK_BIT] && s_r.enable[irq.index] && s_r.pending[irq.index])
    else $error("Maskable request presented while disabled.");
  vec_map_a: assert property (irq.req && irq.index == IDX_LAST
    |-> irq.vector == 16'hFFB8)
    else $error("Vector of last maskable source wrong.");

  trap_rst_c: cover property (run && trap_rst ##1 !core_reset_n);
  clk_rst_c: cover property (clk_rst ##1 s_r.state == RAI_MAL);
  accept_c: cover property (irq.req && irq.index >= IDX_PIN0 && core.accept);
  ext_rst_c: cover property (s_r.state == RAI_EXT ##1 s_r.state == RAI_RUN);
endmodule // rai_ctrl

// ===== tb/rai_core_model.sv
/*
  Behavioural core for the interrupt port: accepts, stacks the mask and returns.
  Assumes one pclk domain and that the controller reads one-cycle pulses.
*/
`timescale 1ns/10ps
module rai_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic acc_en,
  input wire logic swi_go,
  input wire rai_pkg::rai_fetch_type fetch_in,
  input wire rai_pkg::rai_irq_type irq,
  output rai_pkg::rai_core_type core
);
  import rai_pkg::*;
  logic [2:0] cnt_r;
  logic stack_r;
  // Service time is fixed and nothing is accepted meanwhile, so nesting is not exercised.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core <= '0;
      cnt_r <= 3'h0;
      stack_r <= 1'b0;
    end else begin
      core.accept <= 1'b0;
      core.ret <= 1'b0;
      core.fetch <= fetch_in;
      if (swi_go) core.swi_req <= 1'b1;
      if (cnt_r != 3'h0) cnt_r <= cnt_r - 3'h1;
      if (cnt_r == 3'h5) stack_r <= irq.saved_mask;
      if (cnt_r == 3'h1) begin
        core.ret <= 1'b1;
        core.restored_mask <= stack_r;
      end
      if (irq.req && acc_en && cnt_r == 3'h0) begin
        core.accept <= 1'b1;
        cnt_r <= 3'h6;
        if (irq.index == IDX_SWI) core.swi_req <= 1'b0;
      end
    end
  end
endmodule // rai_core_model

// ===== tb/rai_ctrl_test.sv
/*
  Self-checking bench for rai_ctrl: APB registers, reset sources, interrupt order.
  Assumes rai_core_model on the core port and a 50 MHz pclk.
*/
`timescale 1ns/10ps
module rai_ctrl_test;
  import rai_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, core_reset_n;
  logic pin_n = 1'b1, wdt_exp = 1'b0, swi_go = 1'b0;
  logic [15:0] mreq = 16'h0, seed = 16'h0034, r, e;
  logic [15:0] expq[$];
  rai_fetch_type fetch_in = '0;
  rai_core_type core;
  rai_irq_type irq;
  int n_mismatch = 0, num_checks = 0, n;
  always #10 pclk = ~pclk;
  rai_ctrl rai_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_reset_pin_n(pin_n), .watchdog_expired(wdt_exp),
    .maskable_req(mreq), .core(core), .irq(irq), .core_reset_n(core_reset_n),
    .high_osc_enable(), .low_osc_enable(), .system_clock_select());
  rai_core_model rai_core_model_inst (.pclk(pclk), .presetn(presetn), .acc_en(1'b1),
    .swi_go(swi_go), .fetch_in(fetch_in), .irq(irq), .core(core));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic tmo;
    n_mismatch++;
    finish_test();
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 50) tmo();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Counts edges until the internal reset shows the wanted level.
  task automatic wait_rst(input logic lvl);
    #1;
    for (n = 0; n < 200 && core_reset_n !== lvl; n++) begin
      @(posedge pclk);
      #1;
    end
    if (n == 200) tmo();
  endtask
  task automatic drain;
    int i;
    for (i = 0; i < 500 && expq.size() > 0; i++) @(posedge pclk);
    if (expq.size() > 0) tmo();
    repeat (10) @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    if (presetn === 1'b1 && core.accept === 1'b1 && irq.req === 1'b1) begin
      if (expq.size() == 0) chk(32'h1, 32'h0);
      else chk({16'h0, irq.vector}, {16'h0, expq.pop_front()});
    end
  end
  initial begin
    int k;
    int cause[4] = '{8, 8, 2, 4};
    repeat (19) @(posedge pclk);
    chk({15'h0, core_reset_n, irq.vector}, {15'h0, 1'b0, 16'hFFFE});
    @(posedge pclk);
    presetn <= 1'b1;
    wait_rst(1'b1);
    chk(n, 24);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, 32'h0000_00D8);
    apb(1'b0, ENABLE_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, PENDING_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    for (k = 0; k < 4; k++) begin
      // The count starts at the edge that launches the reset, so it always reads 24.
      if (k < 2) begin
        apb(1'b1, CTRL_OFS, (k == 0) ? 32'h03 : 32'h43);
      end else begin
        @(posedge pclk);
        if (k == 2) fetch_in <= rai_fetch_type'(4'hA);
        if (k == 3) wdt_exp <= 1'b1;
        @(posedge pclk);
        fetch_in <= '0;
        wdt_exp <= 1'b0;
      end
      wait_rst(1'b0);
      wait_rst(1'b1);
      chk(n, 24);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk({28'h0, rd[3:0]}, cause[k]);
      apb(1'b0, CTRL_OFS, 32'h0);
      chk(rd, 32'h0000_00D8);
    end
    for (k = 8; k < 21; k += 12) begin
      @(posedge pclk);
      pin_n <= 1'b0;
      repeat (k) @(posedge pclk);
      #1;
      chk({15'h0, core_reset_n, irq.vector}, {15'h0, k < 12, 16'hFFFE});
      @(posedge pclk);
      pin_n <= 1'b1;
      wait_rst(1'b1);
      chk(n <= 4, 1'b1);
    end
    apb(1'b0, STATUS_OFS, 32'h0);
    chk({28'h0, rd[3:0]}, 32'h1);
    apb(1'b1, CTRL_OFS, 32'h0000_00C3);
    r = lfsr(seed);
    e = lfsr(r);
    apb(1'b1, ENABLE_OFS, {12'h0, e, 4'h0});
    expq.push_back(16'hFFF8);
    for (k = 0; k < 16; k++) begin
      if (r[k] & e[k]) expq.push_back(k < 12 ? 16'hFFF6 - 16'(2 * k)
        : 16'hFFBE - 16'(2 * (k - 12)));
    end
    @(posedge pclk);
    mreq <= r;
    wdt_exp <= 1'b1;
    @(posedge pclk);
    mreq <= 16'h0;
    wdt_exp <= 1'b0;
    drain();
    apb(1'b0, PENDING_OFS, 32'h0);
    chk(rd, {12'h0, r & ~e, 4'h0});
    // Non-maskable sources must still be taken with the global mask cleared.
    // Ram trap select is set here so the ram fetch path is exercised below.
    apb(1'b1, CTRL_OFS, 32'h0000_00C6);
    expq.push_back(16'hFFFC);
    @(posedge pclk);
    swi_go <= 1'b1;
    @(posedge pclk);
    swi_go <= 1'b0;
    drain();
    expq.push_back(16'hFFFA);
    @(posedge pclk);
    fetch_in <= rai_fetch_type'(4'h9);
    @(posedge pclk);
    fetch_in <= '0;
    drain();
    chk({31'h0, core_reset_n}, 32'h1);
    finish_test();
  end
endmodule // rai_ctrl_test
